// ==== rtl/ielb_bank.sv ====
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ielb_bank #(
   parameter int NSRC = ielb_pkg::NUM_SRC
) (
   input  wire logic            i_mclk,
   input  wire logic            i_srst,
   input  wire logic [7:0]      i_addr,
   input  wire logic [7:0]      i_wdata,
   input  wire logic            i_wr,
   input  wire logic            i_rd,
   output logic      [7:0]      o_rdata,
   input  wire logic            i_ext_pin_irq_1,
   input  wire logic            i_ext_pin_irq_2,
   input  wire logic            i_ext_pin_irq_3,
   input  wire logic            i_ext_pin_irq_4,
   input  wire logic            i_ext_pin_irq_5,
   input  wire logic [3:0]      i_timer8_irq,
   input  wire logic            i_timer16a_compare_irq_0,
   input  wire logic            i_timer16a_compare_irq_1,
   input  wire logic            i_timer16a_overflow_irq,
   input  wire logic            i_timer16b_compare_irq_0,
   input  wire logic            i_timer16b_compare_irq_1,
   input  wire logic            i_timer16b_overflow_irq,
   input  wire logic            i_serial_a_receive_irq,
   input  wire logic            i_serial_a_transmit_irq,
   input  wire logic            i_serial_b_receive_irq,
   input  wire logic            i_serial_b_transmit_irq,
   input  wire logic            i_serial_bus_irq,
   input  wire logic            i_accept,
   output logic                 o_req_valid,
   output logic      [4:0]      o_req_src,
   output logic      [2:0]      o_req_level,
   output logic                 o_irq
);
   // Request path
   logic [NSRC-1:0] raw;
   logic [NSRC-1:0] sync1_q;
   logic [NSRC-1:0] sync2_q;
   logic [NSRC-1:0] sync3_q;
   logic [NSRC-1:0] req_lvl;

   // Slot interface
   logic [NSRC-1:0] flag;
   logic [NSRC-1:0] evt;
   logic [NSRC-1:0] wr_slot;
   logic [NSRC-1:0] ack_slot;
   logic [2:0]      level [NSRC];
   logic [3:0]      wnib_hi;
   logic [3:0]      slot_w [NSRC];

   // Arbitration
   logic            win_hit_d;
   logic [4:0]      win_src_d;
   logic [2:0]      win_lvl_d;
   logic            acc_hit;

   // Status, mask and bus
   logic [7:0]      stat_q;
   logic [7:0]      mask_q;
   logic [2:0]      stat_set;
   logic [2:0]      stat_clr;
   logic            wr_stat;
   logic            wr_mask;
   logic            irq_d;
   logic [7:0]      rdata_d;

   // Gather request lines into source order
   always_comb begin
      raw = '0;
      raw[ielb_pkg::SRC_PIN1]  = i_ext_pin_irq_1;
      raw[ielb_pkg::SRC_PIN2]  = i_ext_pin_irq_2;
      raw[ielb_pkg::SRC_PIN3]  = i_ext_pin_irq_3;
      raw[ielb_pkg::SRC_T8_0]  = i_timer8_irq[0];
      raw[ielb_pkg::SRC_T8_1]  = i_timer8_irq[1];
      raw[ielb_pkg::SRC_T8_2]  = i_timer8_irq[2];
      raw[ielb_pkg::SRC_T8_3]  = i_timer8_irq[3];
      raw[ielb_pkg::SRC_TA_C0] = i_timer16a_compare_irq_0;
      raw[ielb_pkg::SRC_TA_C1] = i_timer16a_compare_irq_1;
      raw[ielb_pkg::SRC_TA_OV] = i_timer16a_overflow_irq;
      raw[ielb_pkg::SRC_SA_RX] = i_serial_a_receive_irq;
      raw[ielb_pkg::SRC_SA_TX] = i_serial_a_transmit_irq;
      raw[ielb_pkg::SRC_SB_RX] = i_serial_b_receive_irq;
      raw[ielb_pkg::SRC_SB_TX] = i_serial_b_transmit_irq;
      raw[ielb_pkg::SRC_PIN4]  = i_ext_pin_irq_4;
      raw[ielb_pkg::SRC_PIN5]  = i_ext_pin_irq_5;
      raw[ielb_pkg::SRC_TB_C0] = i_timer16b_compare_irq_0;
      raw[ielb_pkg::SRC_TB_C1] = i_timer16b_compare_irq_1;
      raw[ielb_pkg::SRC_TB_OV] = i_timer16b_overflow_irq;
      raw[ielb_pkg::SRC_SBUS]  = i_serial_bus_irq;
   end

   // Three-stage synchroniser chain
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Level accepted once stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         req_lvl <= '0;
      end else begin
         req_lvl <= (sync2_q & sync3_q) | (req_lvl & (sync2_q | sync3_q));
      end
   end

   // Write decode into slot strobes
   always_comb begin
      wr_slot = '0;
      if (i_wr) begin
         unique case (i_addr)
            ielb_pkg::ADDR_PINS12: begin
               wr_slot[ielb_pkg::SRC_PIN1] = 1'b1;
               wr_slot[ielb_pkg::SRC_PIN2] = 1'b1;
            end
            ielb_pkg::ADDR_PIN3: begin
               wr_slot[ielb_pkg::SRC_PIN3] = 1'b1;
            end
            ielb_pkg::ADDR_TMR8_A: begin
               wr_slot[ielb_pkg::SRC_T8_0] = 1'b1;
               wr_slot[ielb_pkg::SRC_T8_1] = 1'b1;
            end
            ielb_pkg::ADDR_TMR8_B: begin
               wr_slot[ielb_pkg::SRC_T8_2] = 1'b1;
               wr_slot[ielb_pkg::SRC_T8_3] = 1'b1;
            end
            ielb_pkg::ADDR_T16A_CMP: begin
               wr_slot[ielb_pkg::SRC_TA_C0] = 1'b1;
               wr_slot[ielb_pkg::SRC_TA_C1] = 1'b1;
            end
            ielb_pkg::ADDR_T16A_OVF: begin
               wr_slot[ielb_pkg::SRC_TA_OV] = 1'b1;
            end
            ielb_pkg::ADDR_SER_A: begin
               wr_slot[ielb_pkg::SRC_SA_RX] = 1'b1;
               wr_slot[ielb_pkg::SRC_SA_TX] = 1'b1;
            end
            ielb_pkg::ADDR_SER_B: begin
               wr_slot[ielb_pkg::SRC_SB_RX] = 1'b1;
               wr_slot[ielb_pkg::SRC_SB_TX] = 1'b1;
            end
            ielb_pkg::ADDR_PINS45: begin
               wr_slot[ielb_pkg::SRC_PIN4] = 1'b1;
               wr_slot[ielb_pkg::SRC_PIN5] = 1'b1;
            end
            ielb_pkg::ADDR_T16B_CMP: begin
               wr_slot[ielb_pkg::SRC_TB_C0] = 1'b1;
               wr_slot[ielb_pkg::SRC_TB_C1] = 1'b1;
            end
            ielb_pkg::ADDR_T16B_OVF: begin
               wr_slot[ielb_pkg::SRC_TB_OV] = 1'b1;
            end
            ielb_pkg::ADDR_SBUS: begin
               wr_slot[ielb_pkg::SRC_SBUS] = 1'b1;
            end
            default: begin
               wr_slot = '0;
            end
         endcase
      end
   end

   // Nibble routing: odd-position sources in a pair take the high nibble
   always_comb begin
      wnib_hi = i_wdata[7:4];
      for (int k = 0; k < NSRC; k++) begin
         slot_w[k] = i_wdata[3:0];
      end
      slot_w[ielb_pkg::SRC_PIN2]  = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_T8_1]  = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_T8_3]  = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_TA_C1] = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_SA_TX] = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_SB_TX] = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_PIN5]  = wnib_hi[3:0];
      slot_w[ielb_pkg::SRC_TB_C1] = wnib_hi[3:0];
   end

   // Bus and acceptance strobes shared by several registers
   always_comb begin
      wr_stat = i_wr && (i_addr == ielb_pkg::ADDR_IRQ_STAT);
      wr_mask = i_wr && (i_addr == ielb_pkg::ADDR_IRQ_MASK);
      acc_hit = i_accept && o_req_valid;
   end

   // Acceptance clears the pending flag of the granted source
   always_comb begin
      ack_slot = '0;
      if (acc_hit) begin
         ack_slot[o_req_src] = 1'b1;
      end
   end

   // One slot per source
   for (genvar g = 0; g < NSRC; g++) begin : g_slot
      ielb_slot u_slot (
         .i_mclk  (i_mclk),
         .i_srst  (i_srst),
         .i_req   (req_lvl[g]),
         .i_ack   (ack_slot[g]),
         .i_wr    (wr_slot[g]),
         .i_wdata (slot_w[g]),
         .o_flag  (flag[g]),
         .o_level (level[g]),
         .o_event (evt[g])
      );
   end

   // Highest pending level wins, lowest index breaks ties; zero is disabled
   always_comb begin
      win_hit_d = 1'b0;
      win_src_d = '0;
      win_lvl_d = ielb_pkg::LEVEL_OFF;
      for (int k = 0; k < NSRC; k++) begin
         if (flag[k] && level[k] != ielb_pkg::LEVEL_OFF && level[k] > win_lvl_d) begin
            win_hit_d = 1'b1;
            win_src_d = 5'(k);
            win_lvl_d = level[k];
         end
      end
   end

   // Request valid toward the CPU; drops for a cycle after each acceptance
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_req_valid <= 1'b0;
      end else begin
         o_req_valid <= win_hit_d && !acc_hit;
      end
   end

   // Index of the winning source
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_req_src <= '0;
      end else begin
         o_req_src <= win_src_d;
      end
   end

   // Level of the winning source
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_req_level <= ielb_pkg::LEVEL_OFF;
      end else begin
         o_req_level <= win_lvl_d;
      end
   end

   // Status events: bit0 new request, bit1 enabled request, bit2 acceptance
   always_comb begin
      stat_set[0] = |evt;
      stat_set[1] = win_hit_d;
      stat_set[2] = acc_hit;
      stat_clr    = wr_stat ? i_wdata[2:0] : 3'h0;
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         stat_q <= ielb_pkg::RESET_VAL;
      end else begin
         stat_q <= {5'h00, stat_set | (stat_q[2:0] & ~stat_clr)};
      end
   end

   // Mask register, same layout as the status
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mask_q <= ielb_pkg::RESET_VAL;
      end else if (wr_mask) begin
         mask_q <= {5'h00, i_wdata[2:0]};
      end
   end

   // Any unmasked status bit raises the line
   always_comb begin
      irq_d = |(stat_q & mask_q);
   end

   // Interrupt output
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_d;
      end
   end

   // Read mux; unused nibbles and unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      unique case (i_addr)
         ielb_pkg::ADDR_PINS12:   rdata_d = {flag[1], level[1], flag[0], level[0]};
         ielb_pkg::ADDR_PIN3:     rdata_d = {4'h0, flag[2], level[2]};
         ielb_pkg::ADDR_TMR8_A:   rdata_d = {flag[4], level[4], flag[3], level[3]};
         ielb_pkg::ADDR_TMR8_B:   rdata_d = {flag[6], level[6], flag[5], level[5]};
         ielb_pkg::ADDR_T16A_CMP: rdata_d = {flag[8], level[8], flag[7], level[7]};
         ielb_pkg::ADDR_T16A_OVF: rdata_d = {4'h0, flag[9], level[9]};
         ielb_pkg::ADDR_SER_A:    rdata_d = {flag[11], level[11], flag[10], level[10]};
         ielb_pkg::ADDR_SER_B:    rdata_d = {flag[13], level[13], flag[12], level[12]};
         ielb_pkg::ADDR_PINS45:   rdata_d = {flag[15], level[15], flag[14], level[14]};
         ielb_pkg::ADDR_T16B_CMP: rdata_d = {flag[17], level[17], flag[16], level[16]};
         ielb_pkg::ADDR_T16B_OVF: rdata_d = {4'h0, flag[18], level[18]};
         ielb_pkg::ADDR_SBUS:     rdata_d = {4'h0, flag[19], level[19]};
         ielb_pkg::ADDR_IRQ_STAT: rdata_d = stat_q;
         ielb_pkg::ADDR_IRQ_MASK: rdata_d = mask_q;
         ielb_pkg::ADDR_PEND_LO:  rdata_d = flag[7:0];
         ielb_pkg::ADDR_PEND_HI:  rdata_d = flag[15:8];
         ielb_pkg::ADDR_PEND_TOP: rdata_d = {4'h0, flag[19:16]};
         ielb_pkg::ADDR_WIN:      rdata_d = {win_hit_d, win_lvl_d[1:0], win_src_d};
         default:                 rdata_d = '0;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= rdata_d;
      end else begin
         o_rdata <= '0;
      end
   end
endmodule : ielb_bank

// ==== rtl/ielb_pkg.sv ====
package ielb_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_PINS12   = 8'hd0;
   localparam logic [7:0] ADDR_PIN3     = 8'hd1;
   localparam logic [7:0] ADDR_TMR8_A   = 8'hd4;
   localparam logic [7:0] ADDR_TMR8_B   = 8'hd5;
   localparam logic [7:0] ADDR_T16A_CMP = 8'hd8;
   localparam logic [7:0] ADDR_T16A_OVF = 8'hda;
   localparam logic [7:0] ADDR_SER_A    = 8'hdb;
   localparam logic [7:0] ADDR_SER_B    = 8'hdc;
   localparam logic [7:0] ADDR_PINS45   = 8'he0;
   localparam logic [7:0] ADDR_T16B_CMP = 8'he1;
   localparam logic [7:0] ADDR_T16B_OVF = 8'he2;
   localparam logic [7:0] ADDR_SBUS     = 8'he3;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hf8;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hf9;
   localparam logic [7:0] ADDR_PEND_LO  = 8'hfa;
   localparam logic [7:0] ADDR_PEND_HI  = 8'hfb;
   localparam logic [7:0] ADDR_PEND_TOP = 8'hfc;
   localparam logic [7:0] ADDR_WIN      = 8'hfd;
   // Slot layout
   localparam int          FLAG_BIT    = 3;
   localparam int          LEVEL_W     = 3;
   localparam int          NUM_SRC     = 20;
   localparam logic [7:0]  RESET_VAL   = 8'h00;
   localparam logic [2:0]  LEVEL_OFF   = 3'h0;
   // Source indices
   localparam int SRC_PIN1 = 0;
   localparam int SRC_PIN2 = 1;
   localparam int SRC_PIN3 = 2;
   localparam int SRC_T8_0 = 3;
   localparam int SRC_T8_1 = 4;
   localparam int SRC_T8_2 = 5;
   localparam int SRC_T8_3 = 6;
   localparam int SRC_TA_C0 = 7;
   localparam int SRC_TA_C1 = 8;
   localparam int SRC_TA_OV = 9;
   localparam int SRC_SA_RX = 10;
   localparam int SRC_SA_TX = 11;
   localparam int SRC_SB_RX = 12;
   localparam int SRC_SB_TX = 13;
   localparam int SRC_PIN4 = 14;
   localparam int SRC_PIN5 = 15;
   localparam int SRC_TB_C0 = 16;
   localparam int SRC_TB_C1 = 17;
   localparam int SRC_TB_OV = 18;
   localparam int SRC_SBUS = 19;
endpackage : ielb_pkg

// ==== rtl/ielb_slot.sv ====
`timescale 1ns/1ps
// One source slot: pending flag and request level
module ielb_slot (
   input  wire logic       i_mclk,
   input  wire logic       i_srst,
   input  wire logic       i_req,
   input  wire logic       i_ack,
   input  wire logic       i_wr,
   input  wire logic [3:0] i_wdata,
   output logic            o_flag,
   output logic [2:0]      o_level,
   output logic            o_event
);
   logic req_q;

   // Pending flag, set on request rising edge, cleared on acceptance; set wins
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_flag <= 1'b0;
         req_q  <= 1'b0;
      end else begin
         req_q <= i_req;
         if (i_req && !req_q) begin
            o_flag <= 1'b1;
         end else if (i_ack) begin
            o_flag <= 1'b0;
         end
      end
   end

   // Level field, written by software
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_level <= ielb_pkg::LEVEL_OFF;
      end else if (i_wr) begin
         o_level <= i_wdata[2:0];
      end
   end

   // Newly raised request pulse
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_event <= 1'b0;
      end else begin
         o_event <= i_req && !req_q;
      end
   end
endmodule : ielb_slot

// ==== tb/ielb_bank_props.sv ====
`timescale 1ns/1ps
// Port-level checks for the enable and level bank
module ielb_bank_props (
   input wire logic       i_mclk,
   input wire logic       i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_accept,
   input wire logic       o_req_valid,
   input wire logic [4:0] o_req_src,
   input wire logic [2:0] o_req_level,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   // Decode of the twelve enable registers
   function automatic logic is_map(input logic [7:0] a);
      return a inside {8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd8, 8'hda,
                       8'hdb, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3};
   endfunction : is_map
   // Write of a mapped register, then a read of the same one
   sequence s_wr_map;
      i_wr && is_map(i_addr);
   endsequence
   sequence s_wr_rd;
      s_wr_map ##1 (i_rd && i_addr == $past(i_addr));
   endsequence
   a_level_readback: assert property (s_wr_rd |=>
      (o_rdata & 8'h77) == ($past(i_wdata, 2) & 8'h77)) else $error("level readback wrong");
   a_reset_clears: assert property ($past(i_srst) |->
      !o_req_valid && !o_irq && o_rdata == 8'h00) else $error("outputs not clear");
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   a_single_upper_zero: assert property (i_rd && i_addr inside {8'hd1, 8'hda, 8'he2, 8'he3}
      |=> o_rdata[7:4] == 4'h0) else $error("unused nibble not zero");
   a_unmapped_zero: assert property (i_rd && !is_map(i_addr) && i_addr < 8'hf8
      |=> o_rdata == 8'h00) else $error("unmapped read not zero");
   a_req_level_on: assert property (o_req_valid |-> o_req_level != 3'h0)
      else $error("request with level zero");
   a_req_src_range: assert property (o_req_valid |-> o_req_src < 5'd20)
      else $error("request source out of range");
   a_req_stands: assert property (o_req_valid && !i_accept && !i_wr && !$past(i_wr)
      |=> o_req_valid) else $error("request dropped before accept");
endmodule : ielb_bank_props

bind ielb_bank ielb_bank_props u_props (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_accept(i_accept),
   .o_req_valid(o_req_valid), .o_req_src(o_req_src), .o_req_level(o_req_level), .o_irq(o_irq));

// ==== tb/ielb_cpu_model.sv ====
`timescale 1ns/1ps
// CPU acceptance side: takes a request some cycles after it shows
module ielb_cpu_model #(
   parameter int DLY = 2
) (
   input  wire logic i_mclk,
   input  wire logic i_srst,
   input  wire logic i_req_valid,
   input  wire logic i_hold,
   output logic      o_accept
);
   int cnt_q;
   // One accept pulse per request, never while stalled
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cnt_q    <= 0;
         o_accept <= 1'b0;
      end else if (o_accept) begin
         o_accept <= 1'b0; // Gap lets the request drop first
         cnt_q    <= 0;
      end else if (i_req_valid && !i_hold) begin
         if (cnt_q == DLY) o_accept <= 1'b1;
         else cnt_q <= cnt_q + 1;
      end
   end
endmodule : ielb_cpu_model

// ==== tb/ielb_bank_bench.sv ====
`timescale 1ns/1ps
// Register access and request tests for the bank
module ielb_bank_bench;
   logic        i_mclk, i_srst, i_wr, i_rd, hold, acc, sg;
   logic [7:0]  i_addr, i_wdata;
   logic [19:0] src;
   wire  [7:0]  o_rdata;
   wire         o_req_valid, o_irq;
   wire  [4:0]  o_req_src;
   wire  [2:0]  o_req_level;
   int          n_errors, total_checks, i;
   logic [7:0]  ra [12] = '{8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd8, 8'hda,
                           8'hdb, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3};
   int          rix [20] = '{0, 0, 1, 2, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 8, 8, 9, 9, 10, 11};
   logic [19:0] hi = 20'h2a952; // Sources that sit in a high nibble
   // Device and CPU side
   ielb_bank i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_ext_pin_irq_1(src[0]), .i_ext_pin_irq_2(src[1]), .i_ext_pin_irq_3(src[2]),
      .i_timer8_irq(src[6:3]), .i_timer16a_compare_irq_0(src[7]),
      .i_timer16a_compare_irq_1(src[8]), .i_timer16a_overflow_irq(src[9]),
      .i_serial_a_receive_irq(src[10]), .i_serial_a_transmit_irq(src[11]),
      .i_serial_b_receive_irq(src[12]), .i_serial_b_transmit_irq(src[13]),
      .i_ext_pin_irq_4(src[14]), .i_ext_pin_irq_5(src[15]),
      .i_timer16b_compare_irq_0(src[16]), .i_timer16b_compare_irq_1(src[17]),
      .i_timer16b_overflow_irq(src[18]), .i_serial_bus_irq(src[19]), .i_accept(acc),
      .o_req_valid(o_req_valid), .o_req_src(o_req_src), .o_req_level(o_req_level),
      .o_irq(o_irq));
   ielb_cpu_model #(.DLY(2)) i_cpu (.i_mclk(i_mclk), .i_srst(i_srst),
      .i_req_valid(o_req_valid), .i_hold(hold), .o_accept(acc));
   // Clock, 4 ns period
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   // Compare and count
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Bus write, entered and left just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
   endtask : wr
   // Bus read, data looked at in the one cycle it stands
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      @(negedge i_mclk);
      chk(o_rdata & m, e);
      @(posedge i_mclk);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc
   // Verdict
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // Watchdog, far beyond the expected run of about five hundred cycles
   initial begin
      #40000;
      n_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      n_errors = 0; total_checks = 0; i_srst = 1'b1; hold = 1'b0;
      i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0; src = 20'h0;
      cyc(3);
      i_srst <= 1'b0;
      for (i = 0; i < 12; i++) rd(ra[i], 8'h00, 8'hff);
      rd(8'hf8, 8'h00, 8'hff);
      $display("test reset done");
      // Levels still zero: flags set but nothing is requested
      for (i = 0; i < 20; i++) begin
         src[i] <= 1'b1;
         cyc(8);
         rd(ra[rix[i]], hi[i] ? 8'h88 : 8'h08, 8'h88);
         @(negedge i_mclk);
         chk({7'h0, o_req_valid}, 8'h00);
         @(posedge i_mclk);
         src[i] <= 1'b0;
      end
      wr(8'hd2, 8'hff);
      rd(8'hd2, 8'h00, 8'hff);
      $display("test map done");
      // Level fields read back, flags stay read-only, pending ones get taken
      for (i = 0; i < 12; i++) begin
         sg = ra[i] inside {8'hd1, 8'hda, 8'he2, 8'he3};
         wr(ra[i], sg ? 8'h0d : 8'hf5);
         rd(ra[i], sg ? 8'h05 : 8'h75, 8'h77);
      end
      cyc(150);
      for (i = 0; i < 12; i++) rd(ra[i], 8'h00, 8'h88);
      $display("test level done");
      // Sticky status, mask and the interrupt line
      rd(8'hf8, 8'h05, 8'h05);
      @(negedge i_mclk);
      chk({7'h0, o_irq}, 8'h00);
      @(posedge i_mclk);
      wr(8'hf9, 8'h04);
      cyc(3);
      @(negedge i_mclk);
      chk({7'h0, o_irq}, 8'h01);
      @(posedge i_mclk);
      wr(8'hf8, 8'h05);
      cyc(3);
      @(negedge i_mclk);
      chk({7'h0, o_irq}, 8'h00);
      @(posedge i_mclk);
      rd(8'hf8, 8'h00, 8'h05);
      wr(8'hf9, 8'h00);
      cyc(1);
      $display("test interrupt done");
      // Higher level wins while the CPU stalls
      hold <= 1'b1;
      wr(8'hd0, 8'h52);
      src[1:0] <= 2'b11;
      cyc(10);
      @(negedge i_mclk);
      chk({3'h0, o_req_src}, 8'h01);
      chk({5'h0, o_req_level}, 8'h05);
      @(posedge i_mclk);
      rd(8'hfd, 8'ha1, 8'hff);
      rd(8'hfa, 8'h03, 8'hff);
      rd(8'hfb, 8'h00, 8'hff);
      rd(8'hfc, 8'h00, 8'hff);
      rd(8'hf8, 8'h03, 8'h03);
      hold <= 1'b0;
      src  <= 20'h0;
      cyc(20);
      @(negedge i_mclk);
      chk({7'h0, o_req_valid}, 8'h00);
      @(posedge i_mclk);
      rd(8'hd0, 8'h00, 8'h88);
      $display("test priority done");
      end_of_test();
   end
endmodule : ielb_bank_bench
